// [pkg/hprc_pkg.sv]
// Constants, types and register map of the host power and reset controller.
// Assumes a 100 MHz pclk and an APB master with 32-bit data.
package hprc_pkg;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_REPLY = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_STATE = 8'h0C;
   localparam logic [7:0] ADDR_BOOT = 8'h10;

   // ----------------------------------------
   // Command and reply codes
   // ----------------------------------------
   localparam logic [7:0] CMD_CFG = 8'h1C;
   localparam logic [7:0] CMD_WDOG = 8'h1D;
   localparam logic [7:0] CMD_QUERY = 8'h1E;
   localparam logic [7:0] REPLY_OK = 8'h40;
   localparam logic [7:0] REPLY_ERR = 8'hC0;
   localparam logic [4:0] QUERY_LEN = 5'h0F;

   // ----------------------------------------
   // Function mask bit positions
   // ----------------------------------------
   localparam int MB_AUTO = 0;
   localparam int MB_RINV = 1;
   localparam int MB_PINV = 2;
   localparam int MB_BLANK = 4;
   localparam int MB_KRST = 5;
   localparam int MB_KPON = 6;
   localparam int MB_KPOFF = 7;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_NS = 10;
   localparam int TICK_NS = 31_250_000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam int TICKS_PER_S = 32;
   localparam int HOLD_LONG_MS = 4000;
   localparam int HOLD_SHORT_MS = 250;
   localparam int RESET_MS = 1000;
   localparam int EXTEND_MS = 5000;
   localparam logic [7:0] HOLD_LONG = 8'(HOLD_LONG_MS * TICKS_PER_S / 1000);
   localparam logic [7:0] HOLD_SHORT = 8'(HOLD_SHORT_MS * TICKS_PER_S / 1000);
   localparam logic [7:0] RESET_TICKS = 8'(RESET_MS * TICKS_PER_S / 1000);
   localparam logic [7:0] EXTEND_TICKS = 8'(EXTEND_MS * TICKS_PER_S / 1000);
   localparam logic [7:0] DEF_PULSE = 8'h20;
   localparam logic [7:0] PULSE_UNTIL = 8'hFF;
   localparam logic [7:0] BOOT_MASK_RST = 8'h00;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] d1;
      logic [7:0] d0;
      logic [7:0] len;
      logic [7:0] code;
   } hprc_cmd_t;

   typedef enum logic [1:0] {
      MSG_NONE, MSG_RESET, MSG_PWR_ON, MSG_PWR_OFF
   } hprc_msg_t;

endpackage

// [verilog/hprc_top.sv]
// Host power and reset controller: keypad gestures, watchdog, blanking.
// Assumes APB access to the command port and pins pulled up by the host.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module hprc_top #(
   parameter int TICK_CYCLES = hprc_pkg::TICK_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic key_confirm,
   input wire logic key_cancel,
   input wire logic host_sense,
   input wire logic reset_line_i,
   output logic reset_line_o,
   output logic reset_line_oe,
   input wire logic power_line_i,
   output logic power_line_o,
   output logic power_line_oe,
   output logic screen_blank,
   output logic backlight_off,
   output hprc_pkg::hprc_msg_t disp_msg
);
   import hprc_pkg::*;

   typedef enum {
      ST_IDLE, ST_RST_PULSE, ST_PWR_PULSE, ST_PWR_EXT, ST_REBOOT
   } hprc_state_t;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   localparam int NSYNC = 5;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] s1_r, s2_r, s3_r, pin_r;
   assign pin_raw = {power_line_i, reset_line_i, host_sense, key_cancel,
                     key_confirm};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s1_r[gi] <= 1'b0;
               s2_r[gi] <= 1'b0;
               s3_r[gi] <= 1'b0;
               pin_r[gi] <= 1'b0;
            end else begin
               s1_r[gi] <= pin_raw[gi];
               s2_r[gi] <= s1_r[gi];
               s3_r[gi] <= s2_r[gi];
               // Change counts only once two stages agree
               if (s2_r[gi] == s3_r[gi]) begin
                  pin_r[gi] <= s3_r[gi];
               end
            end
         end
      end
   endgenerate
   logic confirm, cancel, sense, rst_in, pwr_in;
   assign {pwr_in, rst_in, sense, cancel, confirm} = pin_r;

   // ----------------------------------------
   // Timebase
   // ----------------------------------------
   logic [31:0] pre_r;
   logic [4:0] sub_r;
   logic tick, sec_tick;
   assign tick = (pre_r == 32'(TICK_CYCLES - 1));
   assign sec_tick = tick && (sub_r == 5'(TICKS_PER_S - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_r <= 32'h0;
         sub_r <= 5'h0;
      end else begin
         pre_r <= tick ? 32'h0 : pre_r + 32'h1;
         if (tick) begin
            sub_r <= sub_r + 5'h1;
         end
      end
   end

   // ----------------------------------------
   // Key hold timers
   // ----------------------------------------
   logic [7:0] ok_cnt_r, x_cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ok_cnt_r <= 8'h0;
         x_cnt_r <= 8'h0;
      end else begin
         // Saturation stops a held key firing twice
         if (!confirm) ok_cnt_r <= 8'h0;
         else if (tick && ok_cnt_r != 8'hFF) ok_cnt_r <= ok_cnt_r + 8'h1;
         if (!cancel) x_cnt_r <= 8'h0;
         else if (tick && x_cnt_r != 8'hFF) x_cnt_r <= x_cnt_r + 8'h1;
      end
   end

   // ----------------------------------------
   // APB decode and command port
   // ----------------------------------------
   hprc_state_t state_r;
   hprc_cmd_t cmd;
   logic apb_go, wr_cmd, rd_reply, wr_boot;
   logic [7:0] mask_r, pulse_r, boot_mask_r, boot_pulse_r;
   logic [7:0] wd_cnt_r;
   logic wd_arm_r, wd_pend_r, wd_expire, wd_take, do_reboot;
   logic [7:0] reply_code_r;
   logic [4:0] reply_len_r;
   logic reply_vld_r;
   assign cmd = hprc_cmd_t'(pwdata);
   assign apb_go = psel && penable && pready;
   assign wr_cmd = apb_go && pwrite && paddr == ADDR_CMD &&
                   state_r != ST_REBOOT;
   assign rd_reply = apb_go && !pwrite && paddr == ADDR_REPLY;
   assign wr_boot = apb_go && pwrite && paddr == ADDR_BOOT && pwdata[0];
   assign do_reboot = (state_r == ST_REBOOT);

   logic cfg_ok, wd_ok, qry_ok;
   assign cfg_ok = cmd.code == CMD_CFG &&
                   (cmd.len == 8'h1 || cmd.len == 8'h2);
   assign wd_ok = cmd.code == CMD_WDOG && cmd.len == 8'h1;
   assign qry_ok = cmd.code == CMD_QUERY && cmd.len == 8'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reply_code_r <= 8'h0;
         reply_len_r <= 5'h0;
         reply_vld_r <= 1'b0;
      end else begin
         if (wr_cmd) begin
            reply_vld_r <= 1'b1; // Set wins over the read clear
            reply_len_r <= qry_ok ? QUERY_LEN : 5'h0;
            if (cfg_ok || wd_ok || qry_ok) begin
               reply_code_r <= cmd.code | REPLY_OK;
            end else begin
               reply_code_r <= cmd.code | REPLY_ERR;
            end
         end else if (rd_reply) begin
            reply_vld_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Function settings and boot copy
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= BOOT_MASK_RST;
         pulse_r <= DEF_PULSE;
      end else if (do_reboot) begin
         mask_r <= boot_mask_r;
         pulse_r <= boot_pulse_r;
      end else if (wr_cmd && cfg_ok) begin
         mask_r <= cmd.d0;
         pulse_r <= (cmd.len == 8'h2) ? cmd.d1 : DEF_PULSE;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_mask_r <= BOOT_MASK_RST;
         boot_pulse_r <= DEF_PULSE;
      end else if (wr_boot) begin
         boot_mask_r <= mask_r;
         boot_pulse_r <= pulse_r;
      end
   end

   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   // Runs one second tick past zero: a partial first second never cuts it short
   assign wd_expire = sec_tick && wd_arm_r && wd_cnt_r == 8'h0;
   assign wd_take = (state_r == ST_IDLE) && wd_pend_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_arm_r <= 1'b0;
         wd_cnt_r <= 8'h0;
      end else if (do_reboot) begin
         wd_arm_r <= 1'b0;
         wd_cnt_r <= 8'h0;
      end else if (wr_cmd && wd_ok) begin
         wd_arm_r <= (cmd.d0 != 8'h0);
         wd_cnt_r <= cmd.d0;
      end else if (wd_expire) begin
         wd_arm_r <= 1'b0;
         wd_cnt_r <= 8'h0;
      end else if (sec_tick && wd_arm_r) begin
         wd_cnt_r <= wd_cnt_r - 8'h1;
      end
   end
   // Expiry during a pulse waits rather than being dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_pend_r <= 1'b0;
      end else begin
         wd_pend_r <= wd_expire || (wd_pend_r && !wd_take);
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   logic krst_fire, kpon_fire, kpoff_fire, sense_prev_r, sense_rise;
   logic [7:0] tmr_r;
   logic kp_rst_r, reboot_after_r, off_gest_r, sense0_r;
   logic pulse_end;
   assign krst_fire = mask_r[MB_KRST] && sense && confirm && tick &&
                      ok_cnt_r == HOLD_LONG - 8'h1;
   assign kpon_fire = mask_r[MB_KPON] && !sense && confirm && tick &&
                      ok_cnt_r == HOLD_SHORT - 8'h1;
   assign kpoff_fire = mask_r[MB_KPOFF] && sense && cancel && tick &&
                       x_cnt_r == HOLD_LONG - 8'h1;
   assign sense_rise = sense && !sense_prev_r;
   assign pulse_end = (pulse_r == PULSE_UNTIL) ? (sense != sense0_r)
                      : (tick && tmr_r <= 8'h1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sense_prev_r <= 1'b0;
      end else begin
         sense_prev_r <= sense;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         tmr_r <= 8'h0;
         kp_rst_r <= 1'b0;
         reboot_after_r <= 1'b0;
         off_gest_r <= 1'b0;
         sense0_r <= 1'b0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               sense0_r <= sense;
               if (wd_pend_r) begin
                  state_r <= ST_RST_PULSE;
                  tmr_r <= RESET_TICKS;
                  kp_rst_r <= 1'b0;
               end else if (krst_fire) begin
                  state_r <= ST_RST_PULSE;
                  tmr_r <= RESET_TICKS;
                  kp_rst_r <= 1'b1;
               end else if (kpon_fire || kpoff_fire) begin
                  state_r <= ST_PWR_PULSE;
                  tmr_r <= pulse_r;
                  reboot_after_r <= kpon_fire;
                  off_gest_r <= kpoff_fire;
               end else if (mask_r[MB_BLANK] && sense_rise) begin
                  state_r <= ST_REBOOT;
               end
            end
            ST_RST_PULSE: begin
               if (tick && tmr_r <= 8'h1) begin
                  state_r <= kp_rst_r ? ST_REBOOT : ST_IDLE;
               end else if (tick) begin
                  tmr_r <= tmr_r - 8'h1;
               end
            end
            ST_PWR_PULSE: begin
               if (pulse_end) begin
                  if (off_gest_r && cancel) begin
                     state_r <= ST_PWR_EXT;
                     tmr_r <= EXTEND_TICKS;
                  end else begin
                     state_r <= reboot_after_r ? ST_REBOOT : ST_IDLE;
                  end
               end else if (tick) begin
                  tmr_r <= tmr_r - 8'h1;
               end
            end
            ST_PWR_EXT: begin
               if (!cancel || (tick && tmr_r <= 8'h1)) begin
                  state_r <= ST_IDLE;
               end else if (tick) begin
                  tmr_r <= tmr_r - 8'h1;
               end
            end
            ST_REBOOT: begin
               state_r <= ST_IDLE;
               kp_rst_r <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Line drivers and display
   // ----------------------------------------
   logic rst_idle_r, pwr_idle_r, rst_act, pwr_act;
   logic [3:0] rst_oe_h_r, pwr_oe_h_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_idle_r <= 1'b1;
         pwr_idle_r <= 1'b1;
         rst_oe_h_r <= 4'hF;
         pwr_oe_h_r <= 4'hF;
      end else begin
         // Sync lag: learn only once the released level crossed the chain
         rst_oe_h_r <= {rst_oe_h_r[2:0], reset_line_oe};
         pwr_oe_h_r <= {pwr_oe_h_r[2:0], power_line_oe};
         if (!reset_line_oe && rst_oe_h_r == 4'h0) rst_idle_r <= rst_in;
         if (!power_line_oe && pwr_oe_h_r == 4'h0) pwr_idle_r <= pwr_in;
      end
   end
   assign rst_act = mask_r[MB_AUTO] ? !rst_idle_r : mask_r[MB_RINV];
   assign pwr_act = mask_r[MB_AUTO] ? !pwr_idle_r : mask_r[MB_PINV];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_line_o <= 1'b0;
         reset_line_oe <= 1'b0;
         power_line_o <= 1'b0;
         power_line_oe <= 1'b0;
      end else begin
         reset_line_o <= rst_act;
         power_line_o <= pwr_act;
         reset_line_oe <= (state_r == ST_RST_PULSE);
         power_line_oe <= (state_r == ST_PWR_PULSE ||
                           state_r == ST_PWR_EXT);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         screen_blank <= 1'b0;
         backlight_off <= 1'b0;
         disp_msg <= MSG_NONE;
      end else begin
         screen_blank <= mask_r[MB_BLANK] && !sense;
         backlight_off <= mask_r[MB_BLANK] && !sense;
         if (state_r == ST_RST_PULSE && kp_rst_r) disp_msg <= MSG_RESET;
         else if (state_r == ST_PWR_PULSE && reboot_after_r)
            disp_msg <= MSG_PWR_ON;
         else if (state_r == ST_PWR_PULSE || state_r == ST_PWR_EXT)
            disp_msg <= MSG_PWR_OFF;
         else disp_msg <= MSG_NONE;
      end
   end

   // ----------------------------------------
   // APB read path; no wait states
   // ----------------------------------------
   logic [31:0] rd_val;
   logic rd_hit;
   always_comb begin
      rd_val = 32'h0;
      rd_hit = 1'b1;
      unique case (paddr)
         ADDR_CMD: rd_val = 32'h0;
         ADDR_REPLY: rd_val = {15'h0, reply_vld_r, 3'h0, reply_len_r,
                               reply_code_r};
         ADDR_STATUS: rd_val = {8'h0, pulse_r, wd_cnt_r, mask_r};
         ADDR_STATE: rd_val = {24'h0, 1'b0, wd_arm_r, kp_rst_r,
                               state_r == ST_IDLE, wd_pend_r, rst_act,
                               pwr_act, sense};
         ADDR_BOOT: rd_val = {16'h0, boot_pulse_r, boot_mask_r};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable && !pready;
         if (psel && !penable) begin
            prdata <= pwrite ? 32'h0 : rd_val;
            pslverr <= !rd_hit;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   float_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == ST_IDLE && $past(state_r) == ST_IDLE) |->
         !reset_line_oe && !power_line_oe)
      else $error("line driven while idle");
   cfg_short_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_cmd && cfg_ok && cmd.len == 8'h1 && !do_reboot) |=>
         pulse_r == DEF_PULSE && mask_r == $past(cmd.d0))
      else $error("default pulse not applied");
   cfg_reply_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_cmd && cfg_ok) |=> reply_code_r == 8'h5C && reply_len_r == 5'h0)
      else $error("config reply wrong");
   auto_pol_a: assert property (@(posedge pclk) disable iff (!presetn)
      (reset_line_oe && $past(mask_r[MB_AUTO])) |->
         reset_line_o == !$past(rst_idle_r))
      else $error("auto polarity ignored");
   man_pol_a: assert property (@(posedge pclk) disable iff (!presetn)
      (power_line_oe && $past(mask_r[2:0]) == 3'h0) |-> !power_line_o)
      else $error("power line not active low");
   krst_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == ST_IDLE && !wd_pend_r && !mask_r[MB_KRST]) |=>
         state_r != ST_RST_PULSE)
      else $error("keypad reset while disabled");
   wd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_cmd && wd_ok && cmd.d0 == 8'h0) |=> !wd_arm_r)
      else $error("watchdog armed by zero");
   wd_expire_a: assert property (@(posedge pclk) disable iff (!presetn)
      wd_expire |=> !wd_arm_r ##1 (state_r == ST_RST_PULSE || wd_pend_r))
      else $error("watchdog expiry lost");
   reboot_ign_a: assert property (@(posedge pclk) disable iff (!presetn)
      (do_reboot && apb_go && pwrite && paddr == ADDR_CMD) |=>
         $stable(reply_code_r) && $stable(reply_vld_r))
      else $error("command taken during reboot");
   blank_a: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(mask_r[MB_BLANK]) && !$past(sense)) |-> screen_blank &&
         backlight_off)
      else $error("screen not blanked");
   query_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_cmd && qry_ok) |=> reply_len_r == 5'h0F && reply_code_r == 8'h5E)
      else $error("query reply wrong");

endmodule
`default_nettype wire

// [verif/hprc_board_model.sv]
// Host board model: pull-ups on both control pins and a host power state.
// Assumes the controller drives the pins only through its enables.
`timescale 1ns/100ps
`default_nettype none
module hprc_board_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic reset_line_o,
   input wire logic reset_line_oe,
   input wire logic power_line_o,
   input wire logic power_line_oe,
   output logic reset_line_i,
   output logic power_line_i,
   output logic host_sense
);
   logic pwr_oe_r;
   // ---------------------------------
   // Pins
   // ---------------------------------
   // Released pins float up, never hold the last driven value
   assign reset_line_i = reset_line_oe ? reset_line_o : 1'h1;
   assign power_line_i = power_line_oe ? power_line_o : 1'h1;
   // Host flips power when a power pulse ends, like a front switch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_oe_r <= 1'h0;
         host_sense <= 1'h1;
      end else begin
         pwr_oe_r <= power_line_oe;
         if (pwr_oe_r && !power_line_oe) begin
            host_sense <= !host_sense;
         end
      end
   end
endmodule
`default_nettype wire

// [verif/hprc_top_test.sv]
// Self-checking bench for the host power and reset controller.
// Assumes a shortened timebase of four cycles a tick.
`timescale 1ns/100ps
`default_nettype none
module hprc_top_test;
   import hprc_pkg::*;
   localparam int T = 4;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic key_confirm, key_cancel, host_sense, screen_blank, backlight_off;
   logic reset_line_i, reset_line_o, reset_line_oe;
   logic power_line_i, power_line_o, power_line_oe;
   hprc_msg_t disp_msg;
   int fail_count = 0, checked = 0, cyc = 0, n;
   hprc_top #(.TICK_CYCLES(T)) i_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .key_confirm(key_confirm),
      .key_cancel(key_cancel), .host_sense(host_sense),
      .reset_line_i(reset_line_i), .reset_line_o(reset_line_o),
      .reset_line_oe(reset_line_oe), .power_line_i(power_line_i),
      .power_line_o(power_line_o), .power_line_oe(power_line_oe),
      .screen_blank(screen_blank), .backlight_off(backlight_off),
      .disp_msg(disp_msg));
   hprc_board_model i_board (.pclk(pclk), .presetn(presetn),
      .reset_line_o(reset_line_o), .reset_line_oe(reset_line_oe),
      .power_line_o(power_line_o), .power_line_oe(power_line_oe),
      .reset_line_i(reset_line_i), .power_line_i(power_line_i),
      .host_sense(host_sense));
   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end
   // ---------------------------------
   // Helpers
   // ---------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rng(input int lo, input int hi);
      chk(32'(n >= lo && n <= hi), 32'h1);
   endtask
   // Holds the request until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic cmd(input logic [7:0] c, l, d0, d1, rc,
                      input logic [4:0] rl);
      apb(1'h1, ADDR_CMD, {d1, d0, l, c});
      apb(1'h0, ADDR_REPLY, 32'h0);
      chk(q, {15'h0, 1'h1, 3'h0, rl, rc});
   endtask
   task automatic wait_oe(input logic pw, input int lim);
      n = 0;
      while ((pw ? power_line_oe : reset_line_oe) !== 1'h1 && n < lim) begin
         @(posedge pclk);
         n++;
      end
   endtask
   task automatic pulse_len(input logic pw);
      n = 0;
      while ((pw ? power_line_oe : reset_line_oe) === 1'h1 && n < 999) begin
         @(posedge pclk);
         n++;
      end
   endtask
   // ---------------------------------
   // Scenarios
   // ---------------------------------
   task automatic t_regs;
      apb(1'h0, ADDR_STATUS, 32'h0);
      chk(q, 32'h0020_0000);
      apb(1'h0, 8'h14, 32'h0);
      chk({31'h0, e}, 32'h1);
      cmd(CMD_CFG, 8'h01, 8'hF0, 8'h00, 8'h5C, 5'h00);
      apb(1'h0, ADDR_STATUS, 32'h0);
      chk(q, 32'h0020_00F0);
      apb(1'h1, ADDR_BOOT, 32'h1);
      apb(1'h0, ADDR_BOOT, 32'h0);
      chk(q, 32'h0000_20F0);
      cmd(8'h33, 8'h00, 8'h00, 8'h00, 8'hF3, 5'h00);
      cmd(CMD_QUERY, 8'h00, 8'h00, 8'h00, 8'h5E, 5'h0F);
      $display("t_regs done");
   endtask
   task automatic t_wdog;
      cmd(CMD_CFG, 8'h01, 8'h03, 8'h00, 8'h5C, 5'h00);
      apb(1'h1, ADDR_BOOT, 32'h1);
      cmd(CMD_WDOG, 8'h01, 8'h01, 8'h00, 8'h5D, 5'h00);
      wait_oe(1'h0, 70 * T);
      rng(32 * T, 64 * T);
      chk({31'h0, reset_line_o}, 32'h0);
      pulse_len(1'h0);
      rng(31 * T, 33 * T);
      wait_oe(1'h0, 100 * T);
      chk(n, 100 * T);
      cmd(CMD_WDOG, 8'h01, 8'h02, 8'h00, 8'h5D, 5'h00);
      cmd(CMD_WDOG, 8'h01, 8'h00, 8'h00, 8'h5D, 5'h00);
      wait_oe(1'h0, 70 * T);
      chk(n, 70 * T);
      $display("t_wdog done");
   endtask
   task automatic t_kreset;
      cmd(CMD_CFG, 8'h01, 8'h22, 8'h00, 8'h5C, 5'h00);
      key_confirm <= 1'h1;
      wait_oe(1'h0, 140 * T);
      rng(126 * T, 134 * T);
      chk({31'h0, reset_line_o}, 32'h1);
      chk({30'h0, disp_msg}, {30'h0, MSG_RESET});
      pulse_len(1'h0);
      rng(31 * T, 33 * T);
      key_confirm <= 1'h0;
      apb(1'h0, ADDR_STATUS, 32'h0);
      chk({24'h0, q[7:0]}, 32'h3);
      $display("t_kreset done");
   endtask
   task automatic t_kpoff;
      cmd(CMD_CFG, 8'h02, 8'h84, 8'h04, 8'h5C, 5'h00);
      key_cancel <= 1'h1;
      wait_oe(1'h1, 140 * T);
      rng(126 * T, 134 * T);
      chk({31'h0, power_line_o}, 32'h1);
      chk({30'h0, disp_msg}, {30'h0, MSG_PWR_OFF});
      repeat (20 * T) @(posedge pclk);
      chk({31'h0, power_line_oe}, 32'h1);
      key_cancel <= 1'h0;
      pulse_len(1'h1);
      rng(0, 2 * T);
      $display("t_kpoff done");
   endtask
   task automatic t_kpon;
      cmd(CMD_CFG, 8'h02, 8'h50, 8'h02, 8'h5C, 5'h00);
      repeat (8) @(posedge pclk);
      chk({30'h0, screen_blank, backlight_off}, 32'h3);
      key_confirm <= 1'h1;
      wait_oe(1'h1, 20 * T);
      rng(6 * T, 11 * T);
      chk({31'h0, power_line_o}, 32'h0);
      chk({30'h0, disp_msg}, {30'h0, MSG_PWR_ON});
      pulse_len(1'h1);
      rng(T, 2 * T + 1);
      key_confirm <= 1'h0;
      repeat (12) @(posedge pclk);
      chk({31'h0, screen_blank}, 32'h0);
      apb(1'h0, ADDR_STATUS, 32'h0);
      chk({24'h0, q[7:0]}, 32'h3);
      $display("t_kpon done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Whole run needs about 2400 cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         $display("[FAIL] %0t timeout", $time);
         report_and_stop;
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, key_confirm, key_cancel} = 6'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      repeat (5) @(posedge pclk);
      t_regs;
      t_wdog;
      t_kreset;
      t_kpoff;
      t_kpon;
      report_and_stop;
   end
endmodule
`default_nettype wire
